// >>> hdo_pkg.sv
// Constants shared by the drive-option configuration register and its helpers.
package hdo_pkg;
  localparam logic [7:0] REG_ADDR = 8'h1D;
  localparam logic [7:0] REG_RESET = 8'hA0;
  localparam int NG_HI = 7;
  localparam int NG_LO = 6;
  localparam int ERM_LOOP_BIT = 5;
  localparam int COMP_OFF_BIT = 4;
  localparam int FORMAT_BIT = 3;
  localparam int UPDATE_RATE_BIT = 2;
  localparam int INPUT_TYPE_BIT = 1;
  localparam int LRA_LOOP_BIT = 0;
  localparam logic [7:0] GATE_2PCT = 8'h05;
  localparam logic [7:0] GATE_4PCT = 8'h0A;
  localparam logic [7:0] GATE_8PCT = 8'h14;
  localparam logic [2:0] MODE_EXT_INPUT = 3'h3;
  localparam int COMMUTATION_DIVIDE = 128;
  localparam int SCALE_SHIFT = 7;
  localparam logic [7:0] AMP_MAX = 8'hFF;
  localparam logic [7:0] AMP_ZERO = 8'h00;
  typedef enum logic [1:0] {
    HDO_GATE_OFF,
    HDO_GATE_2PCT,
    HDO_GATE_4PCT,
    HDO_GATE_8PCT
  } hdo_gate_t;
endpackage

// >>> hdo_div_if.sv
// Carrier between the option register and the commutation divider.
`timescale 1ns/10ps
interface hdo_div_if;
  logic enable;
  logic edge_pulse;
  logic phase;
  modport ctrl (output enable, output edge_pulse, input phase);
  modport div (input enable, input edge_pulse, output phase);
endinterface

// >>> hdo_divider.sv
// Divides trigger-pin edge pulses down to the open-loop commutation phase.
`timescale 1ns/10ps
module hdo_divider #(
  parameter int DIVIDE = hdo_pkg::COMMUTATION_DIVIDE
) (
  input wire logic clk_in,
  input wire logic reset_in,
  hdo_div_if.div link
);
  import hdo_pkg::*;
  localparam int HALF = DIVIDE / 2;
  localparam int CW = $clog2(HALF) + 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  if (DIVIDE < 2 || (DIVIDE % 2) != 0) begin : g_bad_divide
    $error("hdo_divider: DIVIDE must be even and at least 2.");
  end

  logic [CW-1:0] count_q;
  logic phase_q;
  wire logic wrap = (count_q == LAST);

  // ---------------------------------------------------------------
  // Half-period counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || !link.enable) begin
      count_q <= CNT_ZERO;
      phase_q <= 1'b0;
    end else if (link.edge_pulse) begin
      count_q <= wrap ? CNT_ZERO : count_q + CW'(1);
      phase_q <= wrap ? ~phase_q : phase_q;
    end
  end

  assign link.phase = phase_q;
endmodule

// >>> hdo_option_reg.sv
// Drive-option configuration register and the drive controls it steers.
//
// Contract
// - noise gate off, 2%, 4% or 8%
// - bit5 picks rotating-mass closed or open loop
// - bit4 set turns supply compensation off
// - bit3 picks signed or unsigned playback values
// - bit2 clear updates linear actuator amplitude once per cycle
// - bit1 picks PWM or analog trigger input
// - bit0 set drives linear actuator open loop
// - open-loop commutation is PWM frequency over 128
`timescale 1ns/10ps
module hdo_option_reg #(
  parameter int DIVIDE = hdo_pkg::COMMUTATION_DIVIDE
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] mode_in,
  input wire logic actuator_is_lra_in,
  input wire logic trigger_input_pin_in,
  input wire logic [7:0] pwm_duty_in,
  input wire logic [7:0] analog_level_in,
  input wire logic [7:0] real_time_playback_in,
  input wire logic [7:0] supply_scale_in,
  input wire logic resonance_cycle_in,
  input wire logic resonance_half_in,
  output logic [7:0] drive_amplitude_out,
  output logic drive_reverse_out,
  output logic amplitude_update_out,
  output logic rotating_mass_closed_loop_out,
  output logic resonant_auto_track_out,
  output logic input_is_analog_out,
  output logic commutation_out
);
  import hdo_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (DIVIDE < 2 || (DIVIDE % 2) != 0) begin : g_bad_divide
    $error("hdo_option_reg: DIVIDE must be even and at least 2.");
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Reads of any other address return zero and leave the register alone.
  logic [7:0] cfg_q;
  logic [7:0] rdata_q;
  wire logic hit = (reg_addr_in == REG_ADDR);
  wire logic cfg_wr = reg_wr_in && hit;
  wire logic [7:0] rdata_d = hit ? cfg_q : AMP_ZERO;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_q <= REG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= AMP_ZERO;
    end else if (reg_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  hdo_gate_t noise_gate_level;
  assign noise_gate_level = hdo_gate_t'(cfg_q[NG_HI:NG_LO]);
  wire logic rotating_mass_loop_select = cfg_q[ERM_LOOP_BIT];
  wire logic supply_compensation_off = cfg_q[COMP_OFF_BIT];
  wire logic playback_value_format = cfg_q[FORMAT_BIT];
  wire logic resonant_update_rate = cfg_q[UPDATE_RATE_BIT];
  wire logic input_type_select = cfg_q[INPUT_TYPE_BIT];
  wire logic resonant_open_loop_select = cfg_q[LRA_LOOP_BIT];

  wire logic ext_mode = (mode_in == MODE_EXT_INPUT);
  wire logic analog_sel = ext_mode && input_type_select;

  // ---------------------------------------------------------------
  // Noise gate
  // ---------------------------------------------------------------
  // Trigger-pin levels below the threshold are treated as silence.
  logic [7:0] gate_level;
  always_comb begin
    unique case (noise_gate_level)
      HDO_GATE_OFF: gate_level = AMP_ZERO;
      HDO_GATE_2PCT: gate_level = GATE_2PCT;
      HDO_GATE_4PCT: gate_level = GATE_4PCT;
      HDO_GATE_8PCT: gate_level = GATE_8PCT;
    endcase
  end

  wire logic [7:0] ext_raw = analog_sel ? analog_level_in : pwm_duty_in;
  wire logic [7:0] ext_gated = (ext_raw < gate_level) ? AMP_ZERO : ext_raw;

  // ---------------------------------------------------------------
  // Real-time playback value
  // ---------------------------------------------------------------
  // Signed values drive their magnitude at twice scale; negative ones flag reverse drive.
  wire logic rtp_negative = !playback_value_format && real_time_playback_in[7];
  wire logic [7:0] rtp_mag = rtp_negative ? 8'(-real_time_playback_in) : real_time_playback_in;
  wire logic [8:0] rtp_doubled = {rtp_mag, 1'b0};
  wire logic [7:0] rtp_signed_amp = rtp_doubled[8] ? AMP_MAX : rtp_doubled[7:0];
  wire logic [7:0] rtp_amp = playback_value_format ? real_time_playback_in : rtp_signed_amp;

  wire logic [7:0] raw_amp = ext_mode ? ext_gated : rtp_amp;
  wire logic raw_reverse = !ext_mode && rtp_negative;

  // ---------------------------------------------------------------
  // Supply compensation
  // ---------------------------------------------------------------
  // A scale of 128 is nominal; results above full scale saturate.
  wire logic [15:0] comp_product = raw_amp * supply_scale_in;
  wire logic [15:0] comp_shifted = comp_product >> SCALE_SHIFT;
  wire logic [7:0] comp_amp = (comp_shifted[15:8] != 8'h00) ? AMP_MAX : comp_shifted[7:0];
  wire logic [7:0] final_amp = supply_compensation_off ? raw_amp : comp_amp;

  // ---------------------------------------------------------------
  // Amplitude update timing
  // ---------------------------------------------------------------
  // A rotating-mass actuator takes a new amplitude on every clock.
  wire logic lra_update = resonance_cycle_in || (resonant_update_rate && resonance_half_in);
  wire logic update_now = actuator_is_lra_in ? lra_update : 1'b1;

  logic [7:0] amp_q;
  logic reverse_q;
  logic update_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      amp_q <= AMP_ZERO;
      reverse_q <= 1'b0;
      update_q <= 1'b0;
    end else begin
      update_q <= update_now;
      if (update_now) begin
        amp_q <= final_amp;
        reverse_q <= raw_reverse;
      end
    end
  end

  // ---------------------------------------------------------------
  // Commutation
  // ---------------------------------------------------------------
  logic pin_prev_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= trigger_input_pin_in;
    end
  end

  hdo_div_if div_link ();
  wire logic open_loop_pwm = actuator_is_lra_in && resonant_open_loop_select && ext_mode && !analog_sel;
  assign div_link.enable = open_loop_pwm;
  assign div_link.edge_pulse = trigger_input_pin_in && !pin_prev_q;

  hdo_divider #(.DIVIDE(DIVIDE)) u_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .link(div_link)
  );

  // Open loop with analog input is not supported, so the phase then follows resonance tracking.
  logic track_phase_q;
  logic comm_q;
  wire logic comm_d = open_loop_pwm ? div_link.phase : track_phase_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      track_phase_q <= 1'b0;
      comm_q <= 1'b0;
    end else begin
      if (resonance_cycle_in) begin
        track_phase_q <= ~track_phase_q;
      end
      comm_q <= comm_d;
    end
  end

  // ---------------------------------------------------------------
  // Mode outputs
  // ---------------------------------------------------------------
  logic erm_closed_q;
  logic lra_auto_q;
  logic analog_q;
  wire logic erm_closed_d = !actuator_is_lra_in && !rotating_mass_loop_select;
  wire logic lra_auto_d = actuator_is_lra_in && !resonant_open_loop_select;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      erm_closed_q <= 1'b0;
      lra_auto_q <= 1'b1;
      analog_q <= 1'b0;
    end else begin
      erm_closed_q <= erm_closed_d;
      lra_auto_q <= lra_auto_d;
      analog_q <= analog_sel;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out = rdata_q;
  assign drive_amplitude_out = amp_q;
  assign drive_reverse_out = reverse_q;
  assign amplitude_update_out = update_q;
  assign rotating_mass_closed_loop_out = erm_closed_q;
  assign resonant_auto_track_out = lra_auto_q;
  assign input_is_analog_out = analog_q;
  assign commutation_out = comm_q;
endmodule

// >>> hdo_option_reg_assertions.sv
// Port-level checks for the drive-option register.
`timescale 1ns/10ps
module hdo_option_reg_assertions #(
  parameter int DIVIDE = hdo_pkg::COMMUTATION_DIVIDE
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [2:0] mode_in,
  input wire logic actuator_is_lra_in,
  input wire logic resonance_cycle_in,
  input wire logic amplitude_update_out,
  input wire logic rotating_mass_closed_loop_out,
  input wire logic resonant_auto_track_out,
  input wire logic input_is_analog_out
);
  import hdo_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [7:0] shadow_q;
  logic hit;
  assign hit = reg_addr_in == REG_ADDR;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shadow_q <= REG_RESET;
    end else if (reg_wr_in && hit) begin
      shadow_q <= reg_wdata_in;
    end
  end
  unmapped_read_a: assert property (reg_rd_in && !hit |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  readback_a: assert property (reg_rd_in && hit |=> reg_rdata_out == $past(shadow_q))
    else $error("read data differs from register");
  read_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  closed_loop_a: assert property (!$past(reset_in) |-> rotating_mass_closed_loop_out ==
    $past(!actuator_is_lra_in && !shadow_q[ERM_LOOP_BIT])) else $error("closed loop select wrong");
  auto_track_a: assert property (!$past(reset_in) |-> resonant_auto_track_out ==
    $past(actuator_is_lra_in && !shadow_q[LRA_LOOP_BIT])) else $error("auto tracking select wrong");
  analog_sel_a: assert property (!$past(reset_in) |-> input_is_analog_out ==
    $past(mode_in == MODE_EXT_INPUT && shadow_q[INPUT_TYPE_BIT])) else $error("input type wrong");
  update_cycle_a: assert property (actuator_is_lra_in && resonance_cycle_in |=> amplitude_update_out)
    else $error("no update on resonance cycle");
  update_once_a: assert property (
    actuator_is_lra_in && !shadow_q[UPDATE_RATE_BIT] && !resonance_cycle_in |=> !amplitude_update_out)
    else $error("extra update in once-per-cycle mode");
endmodule
bind hdo_option_reg hdo_option_reg_assertions #(.DIVIDE(DIVIDE)) i_hdo_option_reg_assertions (.clk_in,
  .reset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .mode_in,
  .actuator_is_lra_in, .resonance_cycle_in, .amplitude_update_out, .rotating_mass_closed_loop_out,
  .resonant_auto_track_out, .input_is_analog_out);

// >>> hdo_option_reg_tb.sv
// Testbench for the drive-option register.
`timescale 1ns/10ps
module hdo_option_reg_tb;
  import hdo_pkg::*;
  localparam int DIV = 8;
  logic clk_in = 1'h0, reset_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0, actuator_is_lra_in = 1'h0;
  logic trigger_input_pin_in = 1'h0, resonance_cycle_in = 1'h0, resonance_half_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pwm_duty_in = 8'h00, supply_scale_in = 8'h80;
  logic [2:0] mode_in = 3'h3;
  logic [7:0] analog_level_in = 8'h00, real_time_playback_in = 8'h00;
  logic [7:0] reg_rdata_out, drive_amplitude_out;
  logic amplitude_update_out, rotating_mass_closed_loop_out, resonant_auto_track_out, input_is_analog_out;
  logic commutation_out, drive_reverse_out;
  int errors = 0, n_compared = 0;
  hdo_option_reg #(.DIVIDE(DIV)) i_hdo_option_reg (.clk_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .mode_in, .actuator_is_lra_in, .trigger_input_pin_in, .pwm_duty_in,
    .analog_level_in, .real_time_playback_in, .supply_scale_in, .resonance_cycle_in,
    .resonance_half_in, .drive_amplitude_out, .drive_reverse_out, .amplitude_update_out,
    .rotating_mass_closed_loop_out, .resonant_auto_track_out, .input_is_analog_out, .commutation_out);
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    tick(1);
    reg_wr_in = 1'h0;
    tick(1);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    tick(1);
    reg_rd_in = 1'h0;
    chk(reg_rdata_out, exp);
    tick(1);
  endtask
  task automatic t_regs();
    rreg(REG_ADDR, REG_RESET);
    wreg(REG_ADDR, 8'h5A);
    rreg(REG_ADDR, 8'h5A);
    wreg(8'h1C, 8'hFF);
    rreg(REG_ADDR, 8'h5A);
    rreg(8'h1C, 8'h00);
    $display("regs done");
  endtask
  task automatic t_modes();
    for (int k = 0; k < 8; k++) begin
      actuator_is_lra_in = k[2];
      wreg(REG_ADDR, {2'h0, k[0], 3'h0, k[0] & ~k[1], k[1]});
      tick(1);
      chk(rotating_mass_closed_loop_out, !k[2] && !k[0]);
      chk(resonant_auto_track_out, k[2] && !k[1]);
      chk(input_is_analog_out, k[0] && !k[1]);
    end
    $display("modes done");
  endtask
  task automatic t_gate();
    logic [7:0] lim [4] = '{GATE_2PCT, GATE_2PCT, GATE_4PCT, GATE_8PCT};
    actuator_is_lra_in = 1'h0;
    for (int g = 0; g < 4; g++) begin
      wreg(REG_ADDR, {g[1:0], 6'h00});
      pwm_duty_in = lim[g] - 8'h01;
      tick(3);
      chk(drive_amplitude_out, (g == 0) ? pwm_duty_in : 8'h00);
      pwm_duty_in = lim[g];
      tick(3);
      chk(drive_amplitude_out, pwm_duty_in);
    end
    supply_scale_in = 8'h40;
    pwm_duty_in = 8'h64;
    tick(3);
    chk(drive_amplitude_out, 8'h32);
    wreg(REG_ADDR, 8'h10);
    tick(2);
    chk(drive_amplitude_out, 8'h64);
    supply_scale_in = 8'h80;
    $display("gate done");
  endtask
  task automatic t_upd();
    actuator_is_lra_in = 1'h1;
    mode_in = 3'h0;
    for (int m = 0; m < 2; m++) begin
      wreg(REG_ADDR, {5'h00, m[0], 2'h0});
      resonance_half_in = 1'h1;
      tick(1);
      resonance_half_in = 1'h0;
      chk(amplitude_update_out, m[0]);
      resonance_cycle_in = 1'h1;
      tick(1);
      resonance_cycle_in = 1'h0;
      chk(amplitude_update_out, 8'h01);
    end
    $display("update done");
  endtask
  task automatic t_comm();
    int n;
    logic prev;
    wreg(REG_ADDR, 8'h01);
    mode_in = 3'h3;
    n = 0;
    for (int c = 0; c < 8 * DIV + 4; c++) begin
      trigger_input_pin_in = ~c[1];
      prev = commutation_out;
      tick(1);
      if (commutation_out !== prev) n++;
    end
    chk(n[7:0], 8'h04);
    $display("commutation done");
  endtask
  task automatic t_play();
    actuator_is_lra_in = 1'h0;
    mode_in = 3'h0;
    real_time_playback_in = 8'hF0;
    wreg(REG_ADDR, 8'h00);
    tick(1);
    chk(drive_amplitude_out, 8'h20);
    chk(drive_reverse_out, 8'h01);
    wreg(REG_ADDR, 8'h08);
    tick(1);
    chk(drive_amplitude_out, 8'hF0);
    chk(drive_reverse_out, 8'h00);
    mode_in = 3'h3;
    analog_level_in = 8'h40;
    wreg(REG_ADDR, 8'h12);
    tick(1);
    chk(drive_amplitude_out, 8'h40);
    chk(input_is_analog_out, 8'h01);
    $display("playback done");
  endtask
  task automatic t_reset();
    actuator_is_lra_in = 1'h0;
    wreg(REG_ADDR, 8'h02);
    chk(rotating_mass_closed_loop_out, 8'h01);
    chk(input_is_analog_out, 8'h01);
    reset_in = 1'h1;
    tick(2);
    chk(rotating_mass_closed_loop_out, 8'h00);
    chk(input_is_analog_out, 8'h00);
    chk(resonant_auto_track_out, 8'h01);
    reset_in = 1'h0;
    rreg(REG_ADDR, REG_RESET);
    chk(rotating_mass_closed_loop_out, 8'h00);
    chk(input_is_analog_out, 8'h00);
    $display("reset done");
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    reset_in = 1'h0;
    t_regs();
    t_modes();
    t_gate();
    t_upd();
    t_comm();
    t_play();
    t_reset();
    finish_test();
  end
  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
